/* File: logic/irq_gate_top.sv */
// apb register block gating descriptor and controller events onto the interrupt line
`timescale 1ns/1ps
module irq_gate_top (
	// clock and reset
	input  wire logic                              CLK_SYS_I,
	input  wire logic                              NRST_I,
	// apb slave
	input  wire logic                              PSEL_I,
	input  wire logic                              PENABLE_I,
	input  wire logic                              PWRITE_I,
	input  wire logic [irq_gate_pkg::ADDR_W-1:0]   PADDR_I,
	input  wire logic [irq_gate_pkg::DATA_W-1:0]   PWDATA_I,
	input  wire logic [3:0]                        PSTRB_I,
	output logic      [irq_gate_pkg::DATA_W-1:0]   PRDATA_O,
	output logic                                   PREADY_O,
	output logic                                   PSLVERR_O,
	// descriptor completions, one pulse per finished descriptor
	input  wire logic [irq_gate_pkg::DATA_W-1:0]   ISO_DONE_I,
	input  wire logic [irq_gate_pkg::DATA_W-1:0]   PERIODIC_DONE_I,
	input  wire logic [irq_gate_pkg::DATA_W-1:0]   BULK_CONTROL_LIST_DONE_I,
	// controller events, one-cycle pulses
	input  wire logic                              CLOCK_STABLE_I,
	input  wire logic                              SUSPEND_ENTRY_I,
	input  wire logic                              DMA_DONE_I,
	input  wire logic                              FRAME_START_I,
	// interrupt
	output logic                                   IRQ_O
);
	// *************************************************************
	// register state
	// *************************************************************
	logic [irq_gate_pkg::DATA_W-1:0] enable_reg;
	logic [irq_gate_pkg::DATA_W-1:0] enable_next;
	logic [irq_gate_pkg::DATA_W-1:0] or_mask_reg   [irq_gate_pkg::LIST_N];
	logic [irq_gate_pkg::DATA_W-1:0] or_mask_next  [irq_gate_pkg::LIST_N];
	logic [irq_gate_pkg::DATA_W-1:0] and_mask_reg  [irq_gate_pkg::LIST_N];
	logic [irq_gate_pkg::DATA_W-1:0] and_mask_next [irq_gate_pkg::LIST_N];
	logic [irq_gate_pkg::DATA_W-1:0] rdata_reg;
	logic [irq_gate_pkg::DATA_W-1:0] rdata_next;
	logic                            irq_reg;
	logic                            irq_next;

	logic [irq_gate_pkg::DATA_W-1:0] status;
	logic [irq_gate_pkg::DATA_W-1:0] status_set;
	logic [irq_gate_pkg::DATA_W-1:0] status_clear;
	logic [irq_gate_pkg::DATA_W-1:0] done_map [irq_gate_pkg::LIST_N];
	logic [irq_gate_pkg::LIST_N-1:0] list_hit;
	logic [irq_gate_pkg::DATA_W-1:0] byte_mask;
	logic [irq_gate_pkg::DATA_W-1:0] rd_mux;
	logic                            wr_access;
	logic                            setup;
	logic                            mapped;

	// *************************************************************
	// apb decode
	// *************************************************************
	assign setup     = PSEL_I && !PENABLE_I;
	assign wr_access = PSEL_I && PENABLE_I && PWRITE_I && mapped;

	always_comb begin
		unique case (PADDR_I)
			irq_gate_pkg::OFS_STATUS,
			irq_gate_pkg::OFS_ENABLE,
			irq_gate_pkg::OFS_ISO_OR,
			irq_gate_pkg::OFS_INT_OR,
			irq_gate_pkg::OFS_BULK_OR,
			irq_gate_pkg::OFS_ISO_AND,
			irq_gate_pkg::OFS_INT_AND,
			irq_gate_pkg::OFS_BULK_AND: mapped = 1'b1;
			default:                    mapped = 1'b0;
		endcase
	end

	genvar gb;
	generate
		for (gb = 0; gb < 4; gb++) begin : g_strb
			assign byte_mask[gb*8 +: 8] = {8{PSTRB_I[gb]}};
		end
	endgenerate

	// zero wait states; unmapped addresses answer with an error
	assign PREADY_O  = 1'b1;
	assign PSLVERR_O = PSEL_I && PENABLE_I && !mapped;

	// *************************************************************
	// read path
	// *************************************************************
	// read data is captured in the setup cycle so it leaves a flop
	always_comb begin
		unique case (PADDR_I)
			irq_gate_pkg::OFS_STATUS:   rd_mux = status;
			irq_gate_pkg::OFS_ENABLE:   rd_mux = enable_reg;
			irq_gate_pkg::OFS_ISO_OR:   rd_mux = or_mask_reg[irq_gate_pkg::LIST_ISO];
			irq_gate_pkg::OFS_INT_OR:   rd_mux = or_mask_reg[irq_gate_pkg::LIST_INT];
			irq_gate_pkg::OFS_BULK_OR:  rd_mux = or_mask_reg[irq_gate_pkg::LIST_BULK];
			irq_gate_pkg::OFS_ISO_AND:  rd_mux = and_mask_reg[irq_gate_pkg::LIST_ISO];
			irq_gate_pkg::OFS_INT_AND:  rd_mux = and_mask_reg[irq_gate_pkg::LIST_INT];
			irq_gate_pkg::OFS_BULK_AND: rd_mux = and_mask_reg[irq_gate_pkg::LIST_BULK];
			default:                    rd_mux = '0;
		endcase
		rdata_next = (setup && !PWRITE_I) ? rd_mux : rdata_reg;
	end

	assign PRDATA_O = rdata_reg;

	// *************************************************************
	// write path
	// *************************************************************
	// reserved enable bits are stored as written; software keeps them zero
	always_comb begin
		enable_next = enable_reg;
		if (wr_access && (PADDR_I == irq_gate_pkg::OFS_ENABLE)) begin
			enable_next = (enable_reg & ~byte_mask) | (PWDATA_I & byte_mask);
		end
	end

	always_comb begin
		or_mask_next  = or_mask_reg;
		and_mask_next = and_mask_reg;
		if (wr_access) begin
			unique case (PADDR_I)
				irq_gate_pkg::OFS_ISO_OR:   or_mask_next[irq_gate_pkg::LIST_ISO] =
					(or_mask_reg[irq_gate_pkg::LIST_ISO] & ~byte_mask) | (PWDATA_I & byte_mask);
				irq_gate_pkg::OFS_INT_OR:   or_mask_next[irq_gate_pkg::LIST_INT] =
					(or_mask_reg[irq_gate_pkg::LIST_INT] & ~byte_mask) | (PWDATA_I & byte_mask);
				irq_gate_pkg::OFS_BULK_OR:  or_mask_next[irq_gate_pkg::LIST_BULK] =
					(or_mask_reg[irq_gate_pkg::LIST_BULK] & ~byte_mask) | (PWDATA_I & byte_mask);
				irq_gate_pkg::OFS_ISO_AND:  and_mask_next[irq_gate_pkg::LIST_ISO] =
					(and_mask_reg[irq_gate_pkg::LIST_ISO] & ~byte_mask) | (PWDATA_I & byte_mask);
				irq_gate_pkg::OFS_INT_AND:  and_mask_next[irq_gate_pkg::LIST_INT] =
					(and_mask_reg[irq_gate_pkg::LIST_INT] & ~byte_mask) | (PWDATA_I & byte_mask);
				irq_gate_pkg::OFS_BULK_AND: and_mask_next[irq_gate_pkg::LIST_BULK] =
					(and_mask_reg[irq_gate_pkg::LIST_BULK] & ~byte_mask) | (PWDATA_I & byte_mask);
				default: ;
			endcase
		end
	end

	// status is write-one-to-clear
	assign status_clear = (wr_access && (PADDR_I == irq_gate_pkg::OFS_STATUS)) ?
		(PWDATA_I & byte_mask) : '0;

	always_ff @(posedge CLK_SYS_I) begin
		if (!NRST_I) begin
			enable_reg <= irq_gate_pkg::RESET_VALUE;
			rdata_reg  <= irq_gate_pkg::RESET_VALUE;
			irq_reg    <= 1'b0;
			for (int i = 0; i < irq_gate_pkg::LIST_N; i++) begin
				or_mask_reg[i]  <= irq_gate_pkg::RESET_VALUE;
				and_mask_reg[i] <= irq_gate_pkg::RESET_VALUE;
			end
		end else begin
			enable_reg   <= enable_next;
			rdata_reg    <= rdata_next;
			irq_reg      <= irq_next;
			or_mask_reg  <= or_mask_next;
			and_mask_reg <= and_mask_next;
		end
	end

	// *************************************************************
	// event sources
	// *************************************************************
	assign done_map[irq_gate_pkg::LIST_ISO]  = ISO_DONE_I;
	assign done_map[irq_gate_pkg::LIST_INT]  = PERIODIC_DONE_I;
	assign done_map[irq_gate_pkg::LIST_BULK] = BULK_CONTROL_LIST_DONE_I;

	genvar gl;
	generate
		for (gl = 0; gl < irq_gate_pkg::LIST_N; gl++) begin : g_list
			list_match u_match (
				.clk_i      (CLK_SYS_I),
				.nrst_i     (NRST_I),
				.or_mask_i  (or_mask_reg[gl]),
				.and_mask_i (and_mask_reg[gl]),
				.done_i     (done_map[gl]),
				.hit_o      (list_hit[gl])
			);
		end
	endgenerate

	// list hits are one cycle behind their completions
	always_comb begin
		status_set                            = '0;
		status_set[irq_gate_pkg::BIT_ISO]      = list_hit[irq_gate_pkg::LIST_ISO];
		status_set[irq_gate_pkg::BIT_BULK]     = list_hit[irq_gate_pkg::LIST_BULK];
		status_set[irq_gate_pkg::BIT_PERIODIC] = list_hit[irq_gate_pkg::LIST_INT];
		status_set[irq_gate_pkg::BIT_CLOCK]    = CLOCK_STABLE_I;
		status_set[irq_gate_pkg::BIT_SUSPEND]  = SUSPEND_ENTRY_I;
		status_set[irq_gate_pkg::BIT_DMA]      = DMA_DONE_I;
		status_set[irq_gate_pkg::BIT_FRAME]    = FRAME_START_I;
	end

	sticky_flags u_status (
		.clk_i   (CLK_SYS_I),
		.nrst_i  (NRST_I),
		.set_i   (status_set),
		.clear_i (status_clear),
		.flags_o (status)
	);

	// *************************************************************
	// interrupt gating
	// *************************************************************
	// the enable only gates the line; status is never touched by it
	always_comb begin
		irq_next = |(status & enable_reg & irq_gate_pkg::IMPL_MASK);
	end

	assign IRQ_O = irq_reg;

	// *************************************************************
	// checks
	// *************************************************************
	property p_reset_clear;
		@(posedge CLK_SYS_I) !NRST_I |=> (enable_reg == '0) && !IRQ_O;
	endproperty
	a_reset_clear: assert property (p_reset_clear) else $error("enable not cleared by reset");

	property p_iso_gate;
		@(posedge CLK_SYS_I) disable iff (!NRST_I)
		(status[irq_gate_pkg::BIT_ISO] && enable_reg[irq_gate_pkg::BIT_ISO]) |=> IRQ_O;
	endproperty
	a_iso_gate: assert property (p_iso_gate) else $error("iso event did not raise irq");

	property p_bulk_gate;
		@(posedge CLK_SYS_I) disable iff (!NRST_I)
		(status[irq_gate_pkg::BIT_BULK] && enable_reg[irq_gate_pkg::BIT_BULK]) |=> IRQ_O;
	endproperty
	a_bulk_gate: assert property (p_bulk_gate) else $error("bulk event did not raise irq");

	property p_periodic_gate;
		@(posedge CLK_SYS_I) disable iff (!NRST_I)
		(status[irq_gate_pkg::BIT_PERIODIC] && enable_reg[irq_gate_pkg::BIT_PERIODIC]) |=> IRQ_O;
	endproperty
	a_periodic_gate: assert property (p_periodic_gate) else $error("periodic event lost");

	property p_clock_event;
		@(posedge CLK_SYS_I) disable iff (!NRST_I)
		(CLOCK_STABLE_I && enable_reg[irq_gate_pkg::BIT_CLOCK]) |=> ##1 IRQ_O;
	endproperty
	a_clock_event: assert property (p_clock_event) else $error("clock stable irq missing");

	property p_suspend_event;
		@(posedge CLK_SYS_I) disable iff (!NRST_I)
		SUSPEND_ENTRY_I |=> status[irq_gate_pkg::BIT_SUSPEND];
	endproperty
	a_suspend_event: assert property (p_suspend_event) else $error("suspend not recorded");

	property p_dma_event;
		@(posedge CLK_SYS_I) disable iff (!NRST_I)
		(DMA_DONE_I && enable_reg[irq_gate_pkg::BIT_DMA]) |=> ##1 IRQ_O;
	endproperty
	a_dma_event: assert property (p_dma_event) else $error("dma done irq missing");

	property p_frame_event;
		@(posedge CLK_SYS_I) disable iff (!NRST_I)
		(FRAME_START_I && enable_reg[irq_gate_pkg::BIT_FRAME]) |=> ##1 IRQ_O;
	endproperty
	a_frame_event: assert property (p_frame_event) else $error("frame start irq missing");

	property p_no_spurious;
		@(posedge CLK_SYS_I) disable iff (!NRST_I)
		((status & enable_reg & irq_gate_pkg::IMPL_MASK) == '0) |=> !IRQ_O;
	endproperty
	a_no_spurious: assert property (p_no_spurious) else $error("irq without enabled source");

	property p_enable_keeps_status;
		@(posedge CLK_SYS_I) disable iff (!NRST_I)
		(wr_access && (PADDR_I == irq_gate_pkg::OFS_ENABLE) && status[irq_gate_pkg::BIT_DMA])
			|=> status[irq_gate_pkg::BIT_DMA];
	endproperty
	a_enable_keeps_status: assert property (p_enable_keeps_status) else $error("status lost");

	property p_enable_write;
		@(posedge CLK_SYS_I) disable iff (!NRST_I)
		(wr_access && (PADDR_I == irq_gate_pkg::OFS_ENABLE) && (PSTRB_I == 4'hF))
			|=> (enable_reg == $past(PWDATA_I));
	endproperty
	a_enable_write: assert property (p_enable_write) else $error("enable write lost");

	property p_bad_addr;
		@(posedge CLK_SYS_I) disable iff (!NRST_I)
		(PSEL_I && PENABLE_I && PWRITE_I && !mapped) |=> $stable(enable_reg);
	endproperty
	a_bad_addr: assert property (p_bad_addr) else $error("unmapped write landed");

	property p_enable_read;
		@(posedge CLK_SYS_I) disable iff (!NRST_I)
		(setup && !PWRITE_I && (PADDR_I == irq_gate_pkg::OFS_ENABLE))
			|=> (PRDATA_O == $past(enable_reg));
	endproperty
	a_enable_read: assert property (p_enable_read) else $error("enable read wrong");

	property p_status_clear;
		@(posedge CLK_SYS_I) disable iff (!NRST_I)
		(wr_access && (PADDR_I == irq_gate_pkg::OFS_STATUS) && PSTRB_I[0]
			&& PWDATA_I[irq_gate_pkg::BIT_DMA] && !DMA_DONE_I)
			|=> !status[irq_gate_pkg::BIT_DMA];
	endproperty
	a_status_clear: assert property (p_status_clear) else $error("dma flag kept");

	property p_or_mask_write;
		@(posedge CLK_SYS_I) disable iff (!NRST_I)
		(wr_access && (PADDR_I == irq_gate_pkg::OFS_INT_OR) && (PSTRB_I == 4'hF))
			|=> (or_mask_reg[irq_gate_pkg::LIST_INT] == $past(PWDATA_I));
	endproperty
	a_or_mask_write: assert property (p_or_mask_write) else $error("mask write lost");

	property p_suspend_gate;
		@(posedge CLK_SYS_I) disable iff (!NRST_I)
		(status[irq_gate_pkg::BIT_SUSPEND] && enable_reg[irq_gate_pkg::BIT_SUSPEND]) |=> IRQ_O;
	endproperty
	a_suspend_gate: assert property (p_suspend_gate) else $error("suspend irq missing");
endmodule

/* File: logic/irq_gate_pkg.sv */
// constants shared by the interrupt enable gating block
// *************************************************************
// *************************************************************
package irq_gate_pkg;
	localparam int                 DATA_W         = 32;
	localparam int                 ADDR_W         = 12;
	localparam int                 LIST_N         = 3;
	// register byte offsets
	localparam logic [ADDR_W-1:0] OFS_STATUS     = 12'h0310;
	localparam logic [ADDR_W-1:0] OFS_ENABLE     = 12'h0314;
	localparam logic [ADDR_W-1:0] OFS_ISO_OR     = 12'h0318;
	localparam logic [ADDR_W-1:0] OFS_INT_OR     = 12'h031C;
	localparam logic [ADDR_W-1:0] OFS_BULK_OR    = 12'h0320;
	localparam logic [ADDR_W-1:0] OFS_ISO_AND    = 12'h0324;
	localparam logic [ADDR_W-1:0] OFS_INT_AND    = 12'h0328;
	localparam logic [ADDR_W-1:0] OFS_BULK_AND   = 12'h032C;
	// bit positions shared by status and enable
	localparam int                 BIT_FRAME      = 1;
	localparam int                 BIT_DMA        = 3;
	localparam int                 BIT_SUSPEND    = 5;
	localparam int                 BIT_CLOCK      = 6;
	localparam int                 BIT_PERIODIC   = 7;
	localparam int                 BIT_BULK       = 8;
	localparam int                 BIT_ISO        = 9;
	// list index order inside the match array
	localparam int                 LIST_ISO       = 0;
	localparam int                 LIST_INT       = 1;
	localparam int                 LIST_BULK      = 2;
	// implemented bits; everything else is reserved
	localparam logic [DATA_W-1:0] IMPL_MASK      = 32'h0000_03EA;
	localparam logic [DATA_W-1:0] RESET_VALUE    = 32'h0000_0000;
endpackage

/* File: logic/sticky_flags.sv */
// sticky event flags, set by hardware and cleared by writing one
`timescale 1ns/1ps
module sticky_flags (
	// clock and reset
	input  wire logic                              clk_i,
	input  wire logic                              nrst_i,
	// set and clear
	input  wire logic [irq_gate_pkg::DATA_W-1:0]   set_i,
	input  wire logic [irq_gate_pkg::DATA_W-1:0]   clear_i,
	// state
	output logic      [irq_gate_pkg::DATA_W-1:0]   flags_o
);
	logic [irq_gate_pkg::DATA_W-1:0] flags_reg;
	logic [irq_gate_pkg::DATA_W-1:0] flags_next;

	// a set in the clearing cycle wins so no event is lost
	always_comb begin
		flags_next = ((flags_reg & ~clear_i) | set_i) & irq_gate_pkg::IMPL_MASK;
	end

	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			flags_reg <= irq_gate_pkg::RESET_VALUE;
		end else begin
			flags_reg <= flags_next;
		end
	end

	assign flags_o = flags_reg;

	property p_set_wins;
		@(posedge clk_i) disable iff (!nrst_i)
		(|(set_i & irq_gate_pkg::IMPL_MASK)) |=> (|(flags_reg & $past(set_i)));
	endproperty
	a_set_wins: assert property (p_set_wins) else $error("set event lost");
endmodule

/* File: logic/list_match.sv */
// completion matcher for one descriptor list under its AND and OR masks
`timescale 1ns/1ps
module list_match (
	// clock and reset
	input  wire logic                              clk_i,
	input  wire logic                              nrst_i,
	// masks and completions
	input  wire logic [irq_gate_pkg::DATA_W-1:0]   or_mask_i,
	input  wire logic [irq_gate_pkg::DATA_W-1:0]   and_mask_i,
	input  wire logic [irq_gate_pkg::DATA_W-1:0]   done_i,
	// result
	output logic                                   hit_o
);
	logic [irq_gate_pkg::DATA_W-1:0] seen_reg;
	logic [irq_gate_pkg::DATA_W-1:0] seen_next;
	logic                            hit_reg;
	logic                            hit_next;
	logic [irq_gate_pkg::DATA_W-1:0] seen_all;
	logic                            and_hit;
	logic                            or_hit;

	// AND waits until every masked descriptor has completed, then rearms;
	// with no mask set at all any completion counts
	always_comb begin
		seen_all  = seen_reg | done_i;
		and_hit   = (|and_mask_i) && ((seen_all & and_mask_i) == and_mask_i);
		or_hit    = |(done_i & or_mask_i);
		hit_next  = and_hit || or_hit || ((or_mask_i == '0) && (and_mask_i == '0) && (|done_i));
		seen_next = and_hit ? '0 : seen_all;
	end

	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			seen_reg <= irq_gate_pkg::RESET_VALUE;
			hit_reg  <= 1'b0;
		end else begin
			seen_reg <= seen_next;
			hit_reg  <= hit_next;
		end
	end

	assign hit_o = hit_reg;

	property p_or_hit;
		@(posedge clk_i) disable iff (!nrst_i)
		(|(done_i & or_mask_i)) |=> hit_o;
	endproperty
	a_or_hit: assert property (p_or_hit) else $error("or match missed");
endmodule

/* File: sim/apb_host.sv */
// host processor model that drives the apb side of the gating block
`timescale 1ns/1ps
module apb_host (
	// clock
	input  wire logic                              clk_i,
	// apb master
	output logic                                   psel_o,
	output logic                                   penable_o,
	output logic                                   pwrite_o,
	output logic      [irq_gate_pkg::ADDR_W-1:0]   paddr_o,
	output logic      [irq_gate_pkg::DATA_W-1:0]   pwdata_o,
	output logic      [3:0]                        pstrb_o,
	input  wire logic [irq_gate_pkg::DATA_W-1:0]   prdata_i,
	input  wire logic                              pready_i,
	input  wire logic                              pslverr_i
);
	initial begin
		psel_o    = 1'b0;
		penable_o = 1'b0;
		pwrite_o  = 1'b0;
		paddr_o   = 12'h000;
		pwdata_o  = 32'h0000_0000;
		pstrb_o   = 4'h0;
	end

	// one transfer; a hang is cut short by the bench watchdog
	task automatic xfer(input logic wr, input logic [11:0] addr, input logic [31:0] data,
		input logic [3:0] strb, output logic [31:0] rdata, output logic err);
		logic [31:0] wd;
		// reserved enable bits always go out as zero
		wd = data;
		if (wr && addr == irq_gate_pkg::OFS_ENABLE) begin
			wd = data & irq_gate_pkg::IMPL_MASK;
		end
		@(posedge clk_i);
		psel_o   <= 1'b1;
		pwrite_o <= wr;
		paddr_o  <= addr;
		pstrb_o  <= strb;
		pwdata_o <= wd;
		@(posedge clk_i);
		penable_o <= 1'b1;
		do @(posedge clk_i); while (pready_i !== 1'b1);
		rdata = prdata_i;
		err   = pslverr_i;
		psel_o    <= 1'b0;
		penable_o <= 1'b0;
		// released lines must not keep showing the last value
		pwdata_o  <= ~pwdata_o;
		paddr_o   <= ~paddr_o;
		pwrite_o  <= ~pwrite_o;
		pstrb_o   <= ~pstrb_o;
	endtask
endmodule

/* File: sim/host_irq_enable_gating_test.sv */
// self-checking bench for the interrupt enable gating block
`timescale 1ns/1ps
module host_irq_enable_gating_test;
	logic        clk;
	logic        nrst;
	logic        psel, penable, pwrite, pready, pslverr, irq;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, iso_done, per_done, bulk_done;
	logic [3:0]  pstrb;
	logic        clk_st, susp, dma, frame;
	logic [31:0] rdata;
	logic        err;
	int          mismatches;
	int          n_tests;
	int          bitpos [7] = '{irq_gate_pkg::BIT_FRAME, irq_gate_pkg::BIT_DMA,
		irq_gate_pkg::BIT_SUSPEND, irq_gate_pkg::BIT_CLOCK, irq_gate_pkg::BIT_PERIODIC,
		irq_gate_pkg::BIT_BULK, irq_gate_pkg::BIT_ISO};
	logic [31:0] m;

	irq_gate_top i_irq_gate_top (.CLK_SYS_I(clk), .NRST_I(nrst), .PSEL_I(psel),
		.PENABLE_I(penable), .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata),
		.PSTRB_I(pstrb), .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr),
		.ISO_DONE_I(iso_done), .PERIODIC_DONE_I(per_done),
		.BULK_CONTROL_LIST_DONE_I(bulk_done), .CLOCK_STABLE_I(clk_st),
		.SUSPEND_ENTRY_I(susp), .DMA_DONE_I(dma), .FRAME_START_I(frame), .IRQ_O(irq));

	apb_host i_apb_host (.clk_i(clk), .psel_o(psel), .penable_o(penable), .pwrite_o(pwrite),
		.paddr_o(paddr), .pwdata_o(pwdata), .pstrb_o(pstrb), .prdata_i(prdata),
		.pready_i(pready), .pslverr_i(pslverr));

	// ************************
	// tasks
	// ************************
	task automatic report_and_stop;
		$display("comparisons %0d mismatches %0d", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	task automatic chk32(input string name, input logic [31:0] exp, input logic [31:0] got);
		n_tests++;
		if (got !== exp) begin
			mismatches++;
			$display("wrong value %s expected %h seen %h", name, exp, got);
		end
	endtask

	task automatic chk1(input string name, input logic exp, input logic got);
		n_tests++;
		if (got !== exp) begin
			mismatches++;
			$display("wrong value %s expected %b seen %b", name, exp, got);
		end
	endtask

	task automatic wr(input logic [11:0] addr, input logic [31:0] data, input logic [3:0] s = 4'hF);
		i_apb_host.xfer(1'b1, addr, data, s, rdata, err);
	endtask

	task automatic rd_chk(input string name, input logic [11:0] addr, input logic [31:0] exp);
		i_apb_host.xfer(1'b0, addr, 32'h0000_0000, 4'h0, rdata, err);
		chk32(name, exp, rdata);
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	// one-cycle event pulse; k selects the source, map the descriptor bits
	task automatic pulse(input int k, input logic [31:0] map);
		@(posedge clk);
		case (k)
			0: frame <= 1'b1;
			1: dma <= 1'b1;
			2: susp <= 1'b1;
			3: clk_st <= 1'b1;
			4: per_done <= map;
			5: bulk_done <= map;
			default: iso_done <= map;
		endcase
		@(posedge clk);
		{frame, dma, susp, clk_st} <= 4'h0;
		{per_done, bulk_done, iso_done} <= '0;
		tick(4);
	endtask

	// ************************
	// clock, watchdog, tests
	// ************************
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	initial begin
		repeat (20000) @(posedge clk);
		mismatches++;
		report_and_stop();
	end

	initial begin
		nrst = 1'b0;
		{frame, dma, susp, clk_st} = 4'h0;
		{per_done, bulk_done, iso_done} = '0;
		mismatches = 0;
		n_tests = 0;
		repeat (10) @(posedge clk);
		nrst <= 1'b1;
		tick(1);
		chk1("irq after reset", 1'b0, irq);
		rd_chk("enable reset", irq_gate_pkg::OFS_ENABLE, 32'h0000_0000);
		chk1("slverr mapped", 1'b0, err);
		rd_chk("status reset", irq_gate_pkg::OFS_STATUS, 32'h0000_0000);
		wr(irq_gate_pkg::OFS_ENABLE, 32'hFFFF_FFFF);
		rd_chk("enable all", irq_gate_pkg::OFS_ENABLE, 32'h0000_03EA);
		wr(irq_gate_pkg::OFS_ENABLE, 32'h0000_0000, 4'b0001);
		rd_chk("enable strobe", irq_gate_pkg::OFS_ENABLE, 32'h0000_0300);
		// every source: pending while disabled, then enabled, then disabled again
		for (int k = 0; k < 7; k++) begin
			m = 32'h0000_0001 << bitpos[k];
			wr(irq_gate_pkg::OFS_ENABLE, irq_gate_pkg::IMPL_MASK & ~m);
			pulse(k, 32'h0000_0001);
			chk1("irq disabled source", 1'b0, irq);
			rd_chk("status pending", irq_gate_pkg::OFS_STATUS, m);
			wr(irq_gate_pkg::OFS_ENABLE, m);
			tick(2);
			chk1("irq enabled source", 1'b1, irq);
			wr(irq_gate_pkg::OFS_ENABLE, 32'h0000_0000);
			tick(2);
			chk1("irq after disable", 1'b0, irq);
			rd_chk("status kept", irq_gate_pkg::OFS_STATUS, m);
			wr(irq_gate_pkg::OFS_STATUS, m);
			rd_chk("status cleared", irq_gate_pkg::OFS_STATUS, 32'h0000_0000);
			// source fires while enabled, then a clear drops the line
			wr(irq_gate_pkg::OFS_ENABLE, m);
			pulse(k, 32'h0000_0001);
			chk1("irq live source", 1'b1, irq);
			rd_chk("status live", irq_gate_pkg::OFS_STATUS, m);
			wr(irq_gate_pkg::OFS_STATUS, m);
			tick(2);
			chk1("irq after clear", 1'b0, irq);
			wr(irq_gate_pkg::OFS_ENABLE, 32'h0000_0000);
		end
		// and condition needs both descriptors, or condition only its own bit
		wr(irq_gate_pkg::OFS_ISO_AND, 32'h0000_0003);
		rd_chk("iso and mask", irq_gate_pkg::OFS_ISO_AND, 32'h0000_0003);
		pulse(6, 32'h0000_0001);
		rd_chk("and partial", irq_gate_pkg::OFS_STATUS, 32'h0000_0000);
		pulse(6, 32'h0000_0002);
		rd_chk("and complete", irq_gate_pkg::OFS_STATUS, 32'h0000_0200);
		wr(irq_gate_pkg::OFS_INT_OR, 32'h8000_0000);
		pulse(4, 32'h0000_0001);
		rd_chk("or miss", irq_gate_pkg::OFS_STATUS, 32'h0000_0200);
		pulse(4, 32'h8000_0000);
		rd_chk("or hit", irq_gate_pkg::OFS_STATUS, 32'h0000_0280);
		wr(irq_gate_pkg::OFS_STATUS, 32'h0000_0280);
		// unmapped place: refused, enable untouched
		wr(12'h300, 32'h0000_0100);
		chk1("slverr write", 1'b1, err);
		rd_chk("unmapped read", 12'h300, 32'h0000_0000);
		chk1("slverr read", 1'b1, err);
		rd_chk("enable unchanged", irq_gate_pkg::OFS_ENABLE, 32'h0000_0000);
		chk1("irq idle", 1'b0, irq);
		// reset in mid-run clears a live interrupt, the enable, status and periodic or mask
		wr(irq_gate_pkg::OFS_ENABLE, irq_gate_pkg::IMPL_MASK);
		pulse(1, 32'h0000_0000);
		chk1("irq before reset", 1'b1, irq);
		@(posedge clk);
		nrst <= 1'b0;
		repeat (2) @(posedge clk);
		nrst <= 1'b1;
		tick(1);
		chk1("irq mid reset", 1'b0, irq);
		rd_chk("enable mid reset", irq_gate_pkg::OFS_ENABLE, 32'h0000_0000);
		rd_chk("status mid reset", irq_gate_pkg::OFS_STATUS, 32'h0000_0000);
		rd_chk("or mask mid reset", irq_gate_pkg::OFS_INT_OR, 32'h0000_0000);
		chk1("pready", 1'b1, pready);
		report_and_stop();
	end
endmodule
